// >>> ccsg_switch_guard.sv
// Purpose: Software clock controls with a guarded CPU clock multiplexer
// Assumes: APB slave, no wait state; stable flags come from oscillators
// Notes:   Select requests wait in the control bits until they are safe
//
// Behaviour
// - Ext input select bit7, mode bit6
// - Main oscillator stop at bit 7
// - HS enable bit2, main select bit0
// - CPU source select at bit 4
// - Internal oscillator stoppable once unused
// - Crystal oscillator stoppable once unused
// - External input disableable once unused
// - Subsystem oscillator stoppable once unused
// - HS enable, mode select write once
//
// The APB register port and the placing of the registers were decided locally.
module ccsg_switch_guard (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [7:0]             paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   x1_stable,
   input  wire logic                   xt1_stable,
   output ccsg_pkg::ccsg_ctrl_type     clk_ctrl
);
   import ccsg_pkg::*;

   logic [1:0]    meta_ff;
   logic [1:0]    stab_ff;
   logic          ext_clk_input_sel_ff;
   logic          main_osc_mode_sel_ff;
   logic          mode_written_ff;
   logic          main_osc_stop_ff;
   logic          hs_sys_clk_enable_ff;
   logic          hs_written_ff;
   logic          main_src_select_ff;
   logic          cpu_src_select_ff;
   logic          int_osc_stop_ff;
   logic          sub_osc_enable_ff;
   ccsg_ctrl_type ctrl_ff;
   ccsg_ctrl_type nxt_ctrl;
   logic [31:0]   prdata_ff;
   logic          pready_ff;
   logic          pslverr_ff;
   logic          wr_en;
   logic          hs_ready;
   logic          int_ready;
   logic          sub_ready;
   logic          mapped;
   logic [31:0]   nxt_rdata;

   // -----------------------------------------------------------------
   // Stability flags from the oscillators
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= 2'h0;
         stab_ff <= 2'h0;
      end else begin
         meta_ff <= {xt1_stable, x1_stable};
         stab_ff <= meta_ff;
      end
   end

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   assign wr_en  = psel & penable & pready_ff & pwrite;
   assign mapped = (paddr == CCSG_OFS_CLOCK_OP_MODE) | (paddr == CCSG_OFS_MAIN_OSC_CTRL) |
                   (paddr == CCSG_OFS_MAIN_CLK_MODE) | (paddr == CCSG_OFS_PROC_CLK) |
                   (paddr == CCSG_OFS_AUX_OSC_CTRL);

   always_comb begin
      nxt_rdata = 32'h0;
      unique case (paddr)
         CCSG_OFS_CLOCK_OP_MODE: begin
            nxt_rdata[CCSG_BIT_EXT_CLK_INPUT_SEL] = ext_clk_input_sel_ff;
            nxt_rdata[CCSG_BIT_MAIN_OSC_MODE_SEL] = main_osc_mode_sel_ff;
         end
         CCSG_OFS_MAIN_OSC_CTRL:
            nxt_rdata[CCSG_BIT_MAIN_OSC_STOP] = main_osc_stop_ff;
         CCSG_OFS_MAIN_CLK_MODE: begin
            nxt_rdata[CCSG_BIT_HS_SYS_CLK_ENABLE] = hs_sys_clk_enable_ff;
            nxt_rdata[CCSG_BIT_MAIN_SRC_STATUS]   = ctrl_ff.main_sel_hs;
            nxt_rdata[CCSG_BIT_MAIN_SRC_SELECT]   = main_src_select_ff;
         end
         CCSG_OFS_PROC_CLK: begin
            nxt_rdata[CCSG_BIT_CPU_SRC_STATUS] = ctrl_ff.cpu_sel_sub;
            nxt_rdata[CCSG_BIT_CPU_SRC_SELECT] = cpu_src_select_ff;
         end
         CCSG_OFS_AUX_OSC_CTRL: begin
            nxt_rdata[CCSG_BIT_INT_OSC_STOP]   = int_osc_stop_ff;
            nxt_rdata[CCSG_BIT_SUB_OSC_ENABLE] = sub_osc_enable_ff;
         end
         default: nxt_rdata = 32'h0;
      endcase
   end

   // No wait state: answer in the first access cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end else begin
         pready_ff  <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~mapped;
         if (psel & ~penable)
            prdata_ff <= nxt_rdata;
      end
   end

   // -----------------------------------------------------------------
   // Control bits
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_clk_input_sel_ff <= 1'b0;
         main_osc_mode_sel_ff <= 1'b0;
         mode_written_ff      <= 1'b0;
      end else if (wr_en && paddr == CCSG_OFS_CLOCK_OP_MODE) begin
         ext_clk_input_sel_ff <= pwdata[CCSG_BIT_EXT_CLK_INPUT_SEL];
         if (!mode_written_ff) begin
            main_osc_mode_sel_ff <= pwdata[CCSG_BIT_MAIN_OSC_MODE_SEL];
            mode_written_ff      <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         main_osc_stop_ff <= CCSG_RST_MAIN_OSC_STOP;
      else if (wr_en && paddr == CCSG_OFS_MAIN_OSC_CTRL)
         main_osc_stop_ff <= pwdata[CCSG_BIT_MAIN_OSC_STOP];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_sys_clk_enable_ff <= 1'b0;
         hs_written_ff        <= 1'b0;
         main_src_select_ff   <= 1'b0;
      end else if (wr_en && paddr == CCSG_OFS_MAIN_CLK_MODE) begin
         main_src_select_ff <= pwdata[CCSG_BIT_MAIN_SRC_SELECT];
         if (!hs_written_ff) begin
            hs_sys_clk_enable_ff <= pwdata[CCSG_BIT_HS_SYS_CLK_ENABLE];
            hs_written_ff        <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         cpu_src_select_ff <= 1'b0;
      else if (wr_en && paddr == CCSG_OFS_PROC_CLK)
         cpu_src_select_ff <= pwdata[CCSG_BIT_CPU_SRC_SELECT];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         int_osc_stop_ff   <= CCSG_RST_INT_OSC_STOP;
         sub_osc_enable_ff <= CCSG_RST_SUB_OSC_EN;
      end else if (wr_en && paddr == CCSG_OFS_AUX_OSC_CTRL) begin
         int_osc_stop_ff   <= pwdata[CCSG_BIT_INT_OSC_STOP];
         sub_osc_enable_ff <= pwdata[CCSG_BIT_SUB_OSC_ENABLE];
      end
   end

   // -----------------------------------------------------------------
   // Guarded multiplexer and oscillator enables
   // -----------------------------------------------------------------
   // Crystal needs its stable flag; an external clock is taken as ready
   assign hs_ready  = ~main_osc_stop_ff & main_osc_mode_sel_ff & hs_sys_clk_enable_ff &
                      (ext_clk_input_sel_ff | stab_ff[0]);
   assign int_ready = ~int_osc_stop_ff;
   assign sub_ready = sub_osc_enable_ff & stab_ff[1];

   always_comb begin
      nxt_ctrl = ctrl_ff;
      // Main switch only with a ready target; otherwise stay put
      if (main_src_select_ff && !ctrl_ff.main_sel_hs && hs_ready)
         nxt_ctrl.main_sel_hs = 1'b1;
      else if (!main_src_select_ff && ctrl_ff.main_sel_hs && int_ready)
         nxt_ctrl.main_sel_hs = 1'b0;
      if (cpu_src_select_ff && !ctrl_ff.cpu_sel_sub && sub_ready)
         nxt_ctrl.cpu_sel_sub = 1'b1;
      else if (!cpu_src_select_ff && ctrl_ff.cpu_sel_sub &&
               (ctrl_ff.main_sel_hs ? hs_ready : int_ready))
         nxt_ctrl.cpu_sel_sub = 1'b0;
      // A source in use is never stopped under the CPU
      nxt_ctrl.int_osc_en  = ~int_osc_stop_ff |
                             (~nxt_ctrl.main_sel_hs & ~nxt_ctrl.cpu_sel_sub);
      nxt_ctrl.main_osc_en = (~main_osc_stop_ff & ~ext_clk_input_sel_ff) |
                             (nxt_ctrl.main_sel_hs & ~nxt_ctrl.cpu_sel_sub &
                              ~ext_clk_input_sel_ff);
      nxt_ctrl.ext_clk_en  = (~main_osc_stop_ff & ext_clk_input_sel_ff) |
                             (nxt_ctrl.main_sel_hs & ~nxt_ctrl.cpu_sel_sub &
                              ext_clk_input_sel_ff);
      nxt_ctrl.sub_osc_en  = sub_osc_enable_ff | nxt_ctrl.cpu_sel_sub;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         ctrl_ff <= '{int_osc_en: 1'b1, default: 1'b0};
      else
         ctrl_ff <= nxt_ctrl;
   end

   assign prdata   = prdata_ff;
   assign pready   = pready_ff;
   assign pslverr  = pslverr_ff;
   assign clk_ctrl = ctrl_ff;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_setup_rd(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   property p_rd_op_mode;
      @(posedge clk) disable iff (!arst_n)
      s_setup_rd(CCSG_OFS_CLOCK_OP_MODE) |=>
         prdata[CCSG_BIT_EXT_CLK_INPUT_SEL] == ext_clk_input_sel_ff &&
         prdata[CCSG_BIT_MAIN_OSC_MODE_SEL] == main_osc_mode_sel_ff;
   endproperty
   a_rd_op_mode: assert property (p_rd_op_mode) else $error("op mode read wrong");
   property p_rd_osc_ctrl;
      @(posedge clk) disable iff (!arst_n)
      s_setup_rd(CCSG_OFS_MAIN_OSC_CTRL) |=>
         pready && prdata[CCSG_BIT_MAIN_OSC_STOP] == main_osc_stop_ff;
   endproperty
   a_rd_osc_ctrl: assert property (p_rd_osc_ctrl) else $error("osc ctrl read wrong");
   property p_rd_clk_mode;
      @(posedge clk) disable iff (!arst_n)
      s_setup_rd(CCSG_OFS_MAIN_CLK_MODE) |=>
         prdata[CCSG_BIT_HS_SYS_CLK_ENABLE] == hs_sys_clk_enable_ff &&
         prdata[CCSG_BIT_MAIN_SRC_SELECT] == main_src_select_ff;
   endproperty
   a_rd_clk_mode: assert property (p_rd_clk_mode) else $error("clock mode read wrong");
   property p_cpu_sel_wr;
      @(posedge clk) disable iff (!arst_n)
      wr_en && paddr == CCSG_OFS_PROC_CLK |=>
         cpu_src_select_ff == $past(pwdata[CCSG_BIT_CPU_SRC_SELECT]);
   endproperty
   a_cpu_sel_wr: assert property (p_cpu_sel_wr) else $error("cpu select not stored");
   property p_hs_guard;
      @(posedge clk) disable iff (!arst_n)
      $rose(clk_ctrl.main_sel_hs) |-> $past(hs_ready) && $past(main_src_select_ff);
   endproperty
   a_hs_guard: assert property (p_hs_guard) else $error("unsafe main switch");
   property p_sub_guard;
      @(posedge clk) disable iff (!arst_n)
      $rose(clk_ctrl.cpu_sel_sub) |-> $past(stab_ff[1]) && $past(sub_osc_enable_ff);
   endproperty
   a_sub_guard: assert property (p_sub_guard) else $error("unsafe sub switch");
   property p_int_kept;
      @(posedge clk) disable iff (!arst_n)
      !clk_ctrl.main_sel_hs && !clk_ctrl.cpu_sel_sub |-> clk_ctrl.int_osc_en;
   endproperty
   a_int_kept: assert property (p_int_kept) else $error("internal stopped in use");
   property p_main_kept;
      @(posedge clk) disable iff (!arst_n)
      // Enables lag the select bit by one edge, hence the past value
      clk_ctrl.main_sel_hs && !clk_ctrl.cpu_sel_sub |->
         ($past(ext_clk_input_sel_ff) ? clk_ctrl.ext_clk_en : clk_ctrl.main_osc_en);
   endproperty
   a_main_kept: assert property (p_main_kept) else $error("main source stopped in use");
   property p_sub_kept;
      @(posedge clk) disable iff (!arst_n)
      clk_ctrl.cpu_sel_sub |-> clk_ctrl.sub_osc_en;
   endproperty
   a_sub_kept: assert property (p_sub_kept) else $error("sub stopped in use");
   property p_hs_once;
      @(posedge clk) disable iff (!arst_n)
      hs_written_ff ##1 wr_en |=> $stable(hs_sys_clk_enable_ff);
   endproperty
   a_hs_once: assert property (p_hs_once) else $error("hs enable rewritten");
endmodule

// >>> ccsg_pkg.sv
// Purpose: Shared constants and types for the CPU clock source switch guard
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Reset values reflect oscillators as they stand after reset
package ccsg_pkg;
   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] CCSG_OFS_CLOCK_OP_MODE = 8'h00;
   localparam logic [7:0] CCSG_OFS_MAIN_OSC_CTRL = 8'h04;
   localparam logic [7:0] CCSG_OFS_MAIN_CLK_MODE = 8'h08;
   localparam logic [7:0] CCSG_OFS_PROC_CLK      = 8'h0c;
   localparam logic [7:0] CCSG_OFS_AUX_OSC_CTRL  = 8'h10;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CCSG_BIT_EXT_CLK_INPUT_SEL = 7;
   localparam int CCSG_BIT_MAIN_OSC_MODE_SEL = 6;
   localparam int CCSG_BIT_MAIN_OSC_STOP     = 7;
   localparam int CCSG_BIT_HS_SYS_CLK_ENABLE = 2;
   localparam int CCSG_BIT_MAIN_SRC_STATUS   = 1;
   localparam int CCSG_BIT_MAIN_SRC_SELECT   = 0;
   localparam int CCSG_BIT_CPU_SRC_STATUS    = 5;
   localparam int CCSG_BIT_CPU_SRC_SELECT    = 4;
   localparam int CCSG_BIT_INT_OSC_STOP      = 0;
   localparam int CCSG_BIT_SUB_OSC_ENABLE    = 1;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic CCSG_RST_MAIN_OSC_STOP = 1'b1;
   localparam logic CCSG_RST_INT_OSC_STOP  = 1'b0;
   localparam logic CCSG_RST_SUB_OSC_EN    = 1'b0;

   // Oscillator and multiplexer controls toward the clock generator
   typedef struct packed {
      logic int_osc_en;
      logic main_osc_en;
      logic ext_clk_en;
      logic sub_osc_en;
      logic main_sel_hs;
      logic cpu_sel_sub;
   } ccsg_ctrl_type;
endpackage

// >>> ccsg_osc_model.sv
// Purpose: Oscillator model answering the clock control enables
// Assumes: settle gives the stabilisation time in clk cycles
// Notes:   Stable flags drop on the next clk edge once an oscillator is disabled
module ccsg_osc_model (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  ccsg_pkg::ccsg_ctrl_type ctrl,
   input  wire logic [7:0]         settle,
   output logic                    x1_stable,
   output logic                    xt1_stable
);
   timeunit 1ns;
   timeprecision 1ps;
   import ccsg_pkg::*;

   logic [7:0]                x1_cnt_ff;
   logic [7:0]                xt1_cnt_ff;

   // ------------------------------------------------------------
   // Stabilisation counters
   // ------------------------------------------------------------
   // Crystal only settles while running, never on the external input
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         x1_cnt_ff <= 8'h00;
      end else if (!ctrl.main_osc_en || ctrl.ext_clk_en) begin
         x1_cnt_ff <= 8'h00;
      end else if (x1_cnt_ff != 8'hff) begin
         x1_cnt_ff <= x1_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xt1_cnt_ff <= 8'h00;
      end else if (!ctrl.sub_osc_en) begin
         xt1_cnt_ff <= 8'h00;
      end else if (xt1_cnt_ff != 8'hff) begin
         xt1_cnt_ff <= xt1_cnt_ff + 8'h01;
      end
   end

   assign x1_stable  = (x1_cnt_ff >= settle) && (x1_cnt_ff != 8'h00);
   assign xt1_stable = (xt1_cnt_ff >= settle) && (xt1_cnt_ff != 8'h00);
endmodule

// >>> ccsg_switch_guard_bench.sv
// Purpose: Self-checking bench for the guarded CPU clock switch
// Assumes: APB slave answers with pready; model drives stable flags
// Notes:   Each select in the crystal, return and subsystem tests is tried unsafe first, then made safe
module ccsg_switch_guard_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ccsg_pkg::*;
   logic                clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr, settle;
   logic [31:0]         pwdata, prdata, rdat;
   logic                rerr, x1_stable, xt1_stable;
   ccsg_ctrl_type       clk_ctrl;
   logic [5:0]          cv;
   int                  n_fail, checks, cycles;

   assign cv = clk_ctrl;

   ccsg_switch_guard dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .x1_stable(x1_stable), .xt1_stable(xt1_stable),
      .clk_ctrl(clk_ctrl));

   ccsg_osc_model osc (.clk(clk), .arst_n(arst_n), .ctrl(clk_ctrl), .settle(settle),
      .x1_stable(x1_stable), .xt1_stable(xt1_stable));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] reset_val(input logic [7:0] a);
      return (a == CCSG_OFS_MAIN_OSC_CTRL) ? 32'h80 : 32'h0;
   endfunction

   // Called just after a rising edge; holds the request until pready
   // Waits for pready without a limit; only the bench timeout ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so a following call never drives psel twice at once
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk({31'h0, rerr}, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdat, exp);
      chk({31'h0, rerr}, 32'h0);
   endtask

   // Bounded wait for a control bit, then compare
   task automatic ctl(input int idx, input logic v);
      int n;
      n = 0;
      while (cv[idx] !== v && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, cv[idx]}, {31'h0, v});
   endtask

   // Refused request: the bit must not move past the sync latency
   task automatic hold(input int idx, input logic v);
      repeat (10) @(posedge clk);
      chk({31'h0, cv[idx]}, {31'h0, v});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] a;
      {psel, penable, pwrite, paddr, pwdata, arst_n} = '0;
      n_fail = 0;
      checks = 0;
      cycles = 0;
      void'($urandom(40));
      settle = 8'h04;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk({26'h0, cv}, 32'h20);
      for (int i = 0; i < 5; i++) rd(8'(4 * i), reset_val(8'(4 * i)));
      for (int i = 0; i < 6; i++) begin
         a = {6'($urandom_range(63, 5)), 2'b00};
         apb(1'b1, a, $urandom);
         chk({31'h0, rerr}, 32'h1);
         apb(1'b0, a, 32'h0);
         chk({31'h0, rerr}, 32'h1);
      end
      $display("test reset and unmapped done");
      wr(8'h00, 32'h40);
      rd(8'h00, 32'h40);
      wr(8'h00, 32'h80);
      rd(8'h00, 32'hc0);
      wr(8'h00, 32'h00);
      rd(8'h00, 32'h40);
      wr(8'h08, 32'h05);
      hold(1, 1'b0);
      rd(8'h08, 32'h05);
      settle <= 8'($urandom_range(30, 3));
      wr(8'h04, 32'h00);
      ctl(4, 1'b1);
      ctl(1, 1'b1);
      rd(8'h08, 32'h07);
      wr(8'h08, 32'h01);
      rd(8'h08, 32'h07);
      $display("test crystal switch done");
      wr(8'h04, 32'h80);
      hold(4, 1'b1);
      rd(8'h04, 32'h80);
      wr(8'h10, 32'h01);
      ctl(5, 1'b0);
      wr(8'h08, 32'h04);
      hold(1, 1'b1);
      wr(8'h10, 32'h00);
      ctl(5, 1'b1);
      ctl(1, 1'b0);
      ctl(4, 1'b0);
      $display("test return to internal done");
      wr(8'h0c, 32'h10);
      hold(0, 1'b0);
      rd(8'h0c, 32'h10);
      settle <= 8'($urandom_range(30, 3));
      wr(8'h10, 32'h02);
      ctl(2, 1'b1);
      ctl(0, 1'b1);
      rd(8'h0c, 32'h30);
      wr(8'h10, 32'h03);
      ctl(5, 1'b0);
      wr(8'h0c, 32'h00);
      hold(0, 1'b1);
      wr(8'h10, 32'h02);
      ctl(5, 1'b1);
      ctl(0, 1'b0);
      wr(8'h10, 32'h00);
      ctl(2, 1'b0);
      $display("test subsystem switch done");
      wr(8'h04, 32'h00);
      wr(8'h08, 32'h05);
      ctl(1, 1'b1);
      wr(8'h10, 32'h02);
      wr(8'h0c, 32'h10);
      ctl(0, 1'b1);
      wr(8'h04, 32'h80);
      ctl(4, 1'b0);
      wr(8'h0c, 32'h00);
      hold(0, 1'b1);
      wr(8'h04, 32'h00);
      ctl(0, 1'b0);
      wr(8'h0c, 32'h10);
      ctl(0, 1'b1);
      wr(8'h00, 32'hc0);
      ctl(3, 1'b1);
      ctl(4, 1'b0);
      wr(8'h0c, 32'h00);
      ctl(0, 1'b0);
      wr(8'h04, 32'h80);
      hold(3, 1'b1);
      wr(8'h08, 32'h04);
      ctl(1, 1'b0);
      ctl(3, 1'b0);
      wr(8'h08, 32'h05);
      hold(1, 1'b0);
      wr(8'h04, 32'h00);
      ctl(1, 1'b1);
      $display("test external input and return from sub done");
      complete_run();
   end
endmodule
